// >>> verilog/scs_pkg.sv
package scs_pkg;
    // Clock and time base
    localparam int unsigned CLK_HZ     = 200_000_000;       // Core clock rate
    localparam int unsigned MS_PER_S   = 1000;              // Milliseconds per second
    localparam int unsigned MS_CYCLES  = CLK_HZ / MS_PER_S; // Cycles in one millisecond
    // Request block word indices
    localparam int unsigned NWORDS = 24;  // Words held in the block store
    localparam int unsigned W_TASK = 0;   // Target port task code
    localparam int unsigned W_LEN  = 1;   // Data block length
    localparam int unsigned W_MODE = 2;   // Completion mode
    localparam int unsigned W_STY  = 3;   // Status word table type
    localparam int unsigned W_SAD  = 4;   // Status word address minus one
    localparam int unsigned W_CMD  = 7;   // Command number
    localparam int unsigned W_ID0  = 8;   // First slave identifier word
    localparam int unsigned W_SES  = 12;  // Session type
    localparam int unsigned W_SLT  = 13;  // Slave table type
    localparam int unsigned W_SLA  = 14;  // Slave table address
    localparam int unsigned W_CNT  = 15;  // Master element count
    localparam int unsigned W_MTY  = 16;  // Master table type
    localparam int unsigned W_MAD  = 17;  // Master table address
    localparam int unsigned W_XTY  = 18;  // Status store type
    localparam int unsigned W_XAD  = 19;  // Status store address
    localparam int unsigned W_TMO  = 20;  // Response timeout in ms
    // Commands, modes, codes
    localparam logic [15:0] CMD_BF_EN = 16'h1b5d; // Re-enable break-free start
    localparam logic [15:0] CMD_XREAD = 16'h1bbd; // Fast read
    localparam logic [15:0] MODE_ASYNC = 16'h0000; // async_completion_mode
    localparam logic [15:0] ST_OK     = 16'h0001; // Success
    localparam logic [15:0] ST_WAIT   = 16'h010c; // Waiting mode refused
    localparam logic [15:0] ST_NOSUP  = 16'h020c; // Not slave or no support
    localparam logic [15:0] ST_PARM   = 16'h0f0c; // Bad request parameters
    localparam logic [15:0] ST_TMO    = 16'h0d0c; // No slave reply in time
    localparam logic [15:0] ST_LINK   = 16'h0c0c; // Link reported failure
    localparam logic [15:0] MT_R      = 16'h0008; // Register table
    localparam logic [15:0] MT_AI     = 16'h000a; // analog_input_table
    localparam logic [15:0] MT_AQ     = 16'h000c; // analog_output_table
    localparam logic [15:0] MT_BYTE_LO = 16'h0010; // First byte-mode type
    localparam logic [15:0] MT_BYTE_HI = 16'h001e; // Last byte-mode type
    localparam logic [15:0] MT_BIT_LO  = 16'h0046; // First bit-mode type
    localparam logic [15:0] TASK_PS = 16'h001f; // Built-in supply port
    localparam logic [15:0] TASK_P1 = 16'h0013; // First extra port
    localparam logic [15:0] TASK_P2 = 16'h0014; // Second extra port
    localparam logic [15:0] MIN_XLEN = 16'd11;   // Least fast-read length
    localparam logic [15:0] MAX_XLEN = 16'd17;   // Eleven plus six optional
    localparam logic [15:0] TMO_LEN  = 16'd13;   // Length that reaches timeout word
    localparam logic [16:0] MAX_BYTES = 17'd1000; // Largest single transfer
    localparam logic [63:0] ID_BCAST = 64'hffff_ffff_ffff_ffff; // Broadcast id
    localparam logic [63:0] ID_NULL  = 64'h0;  // Null id
    localparam logic [15:0] SES_MULTI = 16'h0001; // Multi-session
    // Bus map
    localparam logic [7:0] A_CTRL = 8'h80; // Control: go, disable
    localparam logic [7:0] A_CFG  = 8'h84; // Port configuration
    localparam logic [7:0] A_STAT = 8'h88; // Handler state
    localparam logic [7:0] A_RES  = 8'h8c; // Last result code
    localparam int unsigned B_GO = 0;      // Ctrl: start request
    localparam int unsigned B_DIS = 1;     // Ctrl: disable break-free start
    localparam logic [1:0] CFG_RST = 2'b11; // Slave port, support present
    typedef enum logic [6:0] {
        S_IDLE   = 7'b0000001,
        S_DECODE = 7'b0000010,
        S_ATTACH = 7'b0000100,
        S_READ   = 7'b0001000,
        S_XSTAT  = 7'b0010000,
        S_RESULT = 7'b0100000,
        S_DONE   = 7'b1000000
    } scs_state_t;
endpackage : scs_pkg

// >>> verilog/scs_rsp_timer.sv
`timescale 1ns/1ps
module scs_rsp_timer import scs_pkg::*; #(
    parameter int unsigned CYC_PER_MS = MS_CYCLES // Cycles per millisecond
) (
    input  wire logic        ref_clk_in,  // Clock
    input  wire logic        rst_n_in,    // Async reset, low
    input  wire logic        start_in,    // Load and run
    input  wire logic        stop_in,     // Halt, no expiry
    input  wire logic [15:0] ms_in,       // Wait in ms
    output logic             expired_out  // One-cycle expiry pulse
);
    localparam int unsigned PW = $clog2(CYC_PER_MS + 1);
    localparam logic [PW-1:0] PRE_TOP = PW'(CYC_PER_MS - 1);
    logic [PW-1:0] pre;     // Millisecond prescaler
    logic [15:0]   ms_left; // Milliseconds to go
    logic          run;     // Counting
    // Countdown in whole milliseconds
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre         <= '0;
            ms_left     <= '0;
            run         <= 1'b0;
            expired_out <= 1'b0;
        end else begin
            expired_out <= 1'b0;
            if (start_in) begin // Fresh wait for this request
                pre     <= PRE_TOP;
                ms_left <= ms_in;
                run     <= 1'b1;
            end else if (stop_in) begin
                run <= 1'b0;
            end else if (run) begin
                if (pre != '0) begin
                    pre <= pre - 1'b1;
                end else if (ms_left <= 16'd1) begin // Last ms gone
                    run         <= 1'b0;
                    expired_out <= 1'b1;
                end else begin
                    pre     <= PRE_TOP;
                    ms_left <= ms_left - 16'd1;
                end
            end
        end
    end
    a_no_early_expiry : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        start_in |-> ##1 !expired_out [*2]) else $error("timer expired too early");
endmodule : scs_rsp_timer

// >>> verilog/scs_cmd_handler.sv
`timescale 1ns/1ps
// Behaviour
// - Re-enable matters only after prior disable
// - Active session defers detection until idle timeout
// - Bad status location asserts fault output
// - Success writes one to status word
// - Waiting mode refused with code 010C
// - Non-slave or unsupported port gives 020C
// - Already enabled: no change, still success
// - Built-in port lacking support raises fault
// - Request accepted right after start-up
// - Set up session if needed, then read
// - Fill element count, data taken LSB first
// - Session type plus id decide new session
// - Count in master units, max 1000 bytes
// - Zero response timeout means default
// - Store slave status only when both nonzero
// - Timeout bounds reply wait, per request
module scs_cmd_handler import scs_pkg::*; #(
    parameter int unsigned CYC_PER_MS = MS_CYCLES, // Cycles per millisecond
    parameter logic [15:0] DEF_TMO_MS = 16'd500    // Default reply wait, ms
) (
    input  wire logic        ref_clk_in,        // Clock
    input  wire logic        rst_n_in,          // Async reset, low
    input  wire logic        wb_cyc_in,         // Bus cycle
    input  wire logic        wb_stb_in,         // Bus strobe
    input  wire logic        wb_we_in,          // Bus write
    input  wire logic [7:0]  wb_adr_in,         // Byte address
    input  wire logic [3:0]  wb_sel_in,         // Byte lanes
    input  wire logic [31:0] wb_dat_in,         // Write data
    output logic      [31:0] wb_dat_out,        // Read data
    output logic             wb_ack_out,        // Bus acknowledge
    input  wire logic        session_active_in, // Slave session in progress
    input  wire logic        link_idle_tmo_in,  // Link-idle timeout pulse
    output logic             detect_en_out,     // Break-free start detection on
    output logic             fault_out,         // fault_output of request
    output logic             attach_req_out,    // Session setup request
    output logic             attach_multi_out,  // Setup is multi-session
    input  wire logic        attach_done_in,    // Setup finished
    input  wire logic        attach_err_in,     // Setup failed
    output logic             read_req_out,      // Read request pulse
    output logic      [63:0] slave_id_out,      // Addressed slave id
    output logic      [15:0] slave_type_out,    // Slave table type
    output logic      [15:0] slave_addr_out,    // Slave table address
    output logic      [15:0] read_bytes_out,    // Bytes to fetch
    input  wire logic        rsp_valid_in,      // Response word valid
    input  wire logic [15:0] rsp_data_in,       // Response word
    input  wire logic        rsp_last_in,       // Last response word
    input  wire logic        rsp_err_in,        // Link error
    input  wire logic [15:0] slave_status_in,   // Slave controller status
    output logic             tab_we_out,        // Table write strobe
    output logic      [15:0] tab_type_out,      // Table type
    output logic      [15:0] tab_addr_out,      // Table address
    output logic      [15:0] tab_data_out       // Table data
);
    logic [15:0] blk [NWORDS];   // Request block store
    scs_state_t  state;          // Handler state
    logic [1:0]  cfg;            // Slave flag, support flag
    logic [15:0] res;            // Result code
    logic        done;           // Request finished
    logic        pend;           // Enable waits for session end
    logic        ses_valid;      // Master session up
    logic        ses_multi;      // Session is multi
    logic [63:0] ses_id;         // Single-session partner
    logic        rd_sent;        // Read request issued
    logic [15:0] idx;            // Element write index
    logic        tmr_go;         // Timer start pulse
    logic        tmr_exp;        // Timer expiry
    logic        bus_wr;         // Accepted bus write
    logic        go_req;         // Start request
    logic        dis_req;        // Disable request
    // Decode of the stored block
    logic [63:0] req_id;
    logic [16:0] xbytes;
    logic        sty_ok, bad_x, need_ses, bf_hit, is_bf, is_x;
    logic [15:0] tmo_ms;
    assign req_id = {blk[W_ID0+3], blk[W_ID0+2], blk[W_ID0+1], blk[W_ID0]};
    assign sty_ok = blk[W_STY] == MT_R || blk[W_STY] == MT_AI || blk[W_STY] == MT_AQ;
    assign is_bf  = blk[W_CMD] == CMD_BF_EN;
    assign is_x   = blk[W_CMD] == CMD_XREAD;
    // Byte size of the count in master table units
    always_comb begin
        if (blk[W_MTY] >= MT_BIT_LO) begin
            xbytes = ({1'b0, blk[W_CNT]} + 17'h7) >> 3;
        end else if (blk[W_MTY] >= MT_BYTE_LO && blk[W_MTY] <= MT_BYTE_HI) begin
            xbytes = {1'b0, blk[W_CNT]};
        end else begin
            xbytes = {blk[W_CNT], 1'b0};
        end
    end
    assign bad_x = blk[W_LEN] < MIN_XLEN || blk[W_LEN] > MAX_XLEN
                 || blk[W_SES] > SES_MULTI || req_id == ID_BCAST
                 || (req_id == ID_NULL && blk[W_SES] == SES_MULTI)
                 || xbytes > MAX_BYTES;
    assign need_ses = !ses_valid || ses_multi != blk[W_SES][0]
                    || (!blk[W_SES][0] && ses_id != req_id);
    assign tmo_ms = (blk[W_LEN] >= TMO_LEN && blk[W_TMO] != 16'h0)
                  ? blk[W_TMO] : DEF_TMO_MS;
    assign bf_hit = state == S_DECODE && sty_ok && is_bf && blk[W_MODE] == MODE_ASYNC
                  && cfg[0] && cfg[1];
    assign bus_wr = wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in;
    assign go_req = bus_wr && wb_adr_in == A_CTRL && wb_sel_in[0] && wb_dat_in[B_GO];
    assign dis_req = bus_wr && wb_adr_in == A_CTRL && wb_sel_in[0] && wb_dat_in[B_DIS];

    // Bus slave: one wait state, unmapped reads zero
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
            cfg        <= CFG_RST;
        end else begin
            wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
            if (bus_wr && wb_adr_in == A_CFG && wb_sel_in[0]) begin // Port setup
                cfg <= wb_dat_in[1:0];
            end
            if (!wb_adr_in[7] && wb_adr_in[6:2] < 5'(NWORDS)) begin // Block word
                wb_dat_out <= {16'h0, blk[wb_adr_in[6:2]]};
            end else begin
                unique case (wb_adr_in)
                    A_CFG:   wb_dat_out <= {30'h0, cfg};
                    A_STAT:  wb_dat_out <= {26'h0, ses_valid, pend, detect_en_out,
                                            fault_out, done, state != S_IDLE};
                    A_RES:   wb_dat_out <= {16'h0, res};
                    default: wb_dat_out <= '0; // Unmapped or ctrl
                endcase
            end
        end
    end

    // Request block store, byte lanes honoured
    genvar gi;
    generate
        for (gi = 0; gi < NWORDS; gi++) begin : g_blk
            always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    blk[gi] <= '0;
                end else if (bus_wr && !wb_adr_in[7] && wb_adr_in[6:2] == 5'(gi)
                             && state == S_IDLE) begin
                    if (wb_sel_in[0]) blk[gi][7:0] <= wb_dat_in[7:0];
                    if (wb_sel_in[1]) blk[gi][15:8] <= wb_dat_in[15:8];
                end
            end
        end
    endgenerate

    // Break-free start detection; on from power-up
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            detect_en_out <= 1'b1;
            pend          <= 1'b0;
        end else if (dis_req) begin
            detect_en_out <= 1'b0;
            pend          <= 1'b0;
        end else if (bf_hit && !detect_en_out && !pend) begin
            if (session_active_in) begin
                pend <= 1'b1; // Keep session, wait for idle end
            end else begin
                detect_en_out <= 1'b1;
            end
        end else if (pend && link_idle_tmo_in) begin
            detect_en_out <= 1'b1;
            pend          <= 1'b0;
        end
    end

    scs_rsp_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .start_in    (tmr_go),
        .stop_in     (state != S_ATTACH && state != S_READ),
        .ms_in       (tmo_ms),
        .expired_out (tmr_exp)
    );

    // Request sequencer
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= S_IDLE;
            res <= '0; done <= 1'b0; fault_out <= 1'b0;
            ses_valid <= 1'b0; ses_multi <= 1'b0; ses_id <= '0;
            rd_sent <= 1'b0; idx <= '0; tmr_go <= 1'b0;
            attach_req_out <= 1'b0; attach_multi_out <= 1'b0; read_req_out <= 1'b0;
            slave_id_out <= '0; slave_type_out <= '0; slave_addr_out <= '0;
            read_bytes_out <= '0;
            tab_we_out <= 1'b0; tab_type_out <= '0; tab_addr_out <= '0; tab_data_out <= '0;
        end else begin
            tab_we_out   <= 1'b0;
            tmr_go       <= 1'b0;
            read_req_out <= 1'b0;
            if (link_idle_tmo_in) ses_valid <= 1'b0; // Idle link drops session
            unique case (state)
                S_IDLE: if (go_req) begin // No start-up hold-off
                    state <= S_DECODE; done <= 1'b0; fault_out <= 1'b0;
                end
                S_DECODE: begin
                    slave_id_out   <= req_id;
                    slave_type_out <= blk[W_SLT];
                    slave_addr_out <= blk[W_SLA];
                    read_bytes_out <= xbytes[15:0];
                    idx <= '0; rd_sent <= 1'b0;
                    if (!sty_ok) begin // No status write possible
                        fault_out <= 1'b1; state <= S_DONE;
                    end else if (blk[W_MODE] != MODE_ASYNC) begin
                        res <= ST_WAIT; state <= S_RESULT;
                    end else if (is_bf && (!cfg[0] || !cfg[1])) begin
                        if (blk[W_TASK] == TASK_PS && !cfg[1]) begin
                            fault_out <= 1'b1; state <= S_DONE;
                        end else begin
                            res <= ST_NOSUP; state <= S_RESULT;
                        end
                    end else if (is_bf) begin
                        res <= ST_OK; state <= S_RESULT;
                    end else if (!is_x) begin
                        res <= ST_NOSUP; state <= S_RESULT;
                    end else if (bad_x) begin
                        res <= ST_PARM; state <= S_RESULT;
                    end else if (need_ses) begin
                        attach_req_out   <= 1'b1;
                        attach_multi_out <= blk[W_SES][0];
                        tmr_go <= 1'b1; state <= S_ATTACH;
                    end else begin
                        tmr_go <= 1'b1; state <= S_READ;
                    end
                end
                S_ATTACH: if (attach_done_in) begin
                    attach_req_out <= 1'b0;
                    ses_valid <= 1'b1; ses_multi <= attach_multi_out; ses_id <= slave_id_out;
                    tmr_go <= 1'b1; state <= S_READ;
                end else if (attach_err_in || tmr_exp) begin
                    attach_req_out <= 1'b0; ses_valid <= 1'b0;
                    res <= attach_err_in ? ST_LINK : ST_TMO; state <= S_RESULT;
                end
                S_READ: if (!rd_sent) begin
                    read_req_out <= 1'b1; rd_sent <= 1'b1;
                end else if (rsp_err_in || tmr_exp) begin
                    ses_valid <= 1'b0;
                    res <= rsp_err_in ? ST_LINK : ST_TMO; state <= S_RESULT;
                end else if (rsp_valid_in) begin // Words land LSB first
                    tab_we_out   <= 1'b1;
                    tab_type_out <= blk[W_MTY];
                    tab_addr_out <= blk[W_MAD] + idx;
                    tab_data_out <= rsp_data_in;
                    idx <= idx + 16'd1;
                    if (rsp_last_in) begin
                        res <= ST_OK; state <= S_XSTAT;
                    end
                end
                S_XSTAT: begin
                    if (blk[W_XTY] != 16'h0 && blk[W_XAD] != 16'h0) begin
                        tab_we_out <= 1'b1; tab_type_out <= blk[W_XTY];
                        tab_addr_out <= blk[W_XAD]; tab_data_out <= slave_status_in;
                    end
                    state <= S_RESULT;
                end
                S_RESULT: begin // Status word at address plus one
                    tab_we_out <= 1'b1; tab_type_out <= blk[W_STY];
                    tab_addr_out <= blk[W_SAD] + 16'd1; tab_data_out <= res;
                    state <= S_DONE;
                end
                S_DONE: begin
                    done <= 1'b1; state <= S_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence q_bf_dec;
        state == S_DECODE && sty_ok && is_bf;
    endsequence
    sequence q_code(logic [15:0] c);
        ##2 tab_we_out && tab_data_out == c;
    endsequence
    a_fault_no_write : assert property (
        state == S_DECODE && !sty_ok |-> ##1 fault_out && !tab_we_out ##1 !tab_we_out)
        else $error("bad status location not faulted");
    a_wait_refused : assert property (
        q_bf_dec and blk[W_MODE] != MODE_ASYNC |-> q_code(ST_WAIT))
        else $error("waiting mode not refused");
    a_nosup_code : assert property (
        q_bf_dec and blk[W_MODE] == MODE_ASYNC && cfg[1] && !cfg[0] |-> q_code(ST_NOSUP))
        else $error("unsupported port code wrong");
    a_builtin_fault : assert property (
        q_bf_dec and blk[W_MODE] == MODE_ASYNC && !cfg[1] && blk[W_TASK] == TASK_PS
        |-> ##1 fault_out) else $error("built-in port fault missing");
    a_enabled_ok : assert property (
        bf_hit && detect_en_out |-> ##1 detect_en_out ##1 tab_we_out && tab_data_out == ST_OK)
        else $error("repeat enable not success");
    a_defer_enable : assert property (
        bf_hit && !detect_en_out && !pend && session_active_in && !dis_req
        |-> ##1 pend && !detect_en_out) else $error("enable not deferred");
    a_idle_release : assert property (
        pend && link_idle_tmo_in && !dis_req |=> detect_en_out && !pend)
        else $error("idle timeout did not enable");
    a_bad_x_refused : assert property (
        state == S_DECODE && sty_ok && is_x && blk[W_MODE] == MODE_ASYNC && bad_x
        |-> (!attach_req_out [*3]) and q_code(ST_PARM)) else $error("bad fast read started");
    a_attach_first : assert property (
        state == S_DECODE && sty_ok && is_x && blk[W_MODE] == MODE_ASYNC && !bad_x
        && need_ses |=> attach_req_out && !read_req_out) else $error("session not set up");
    a_xstat_gate : assert property (
        state == S_XSTAT && (blk[W_XTY] == 16'h0 || blk[W_XAD] == 16'h0) |=> !tab_we_out)
        else $error("slave status stored without location");
endmodule : scs_cmd_handler

// >>> test/scs_link_model.sv
`timescale 1ns/1ps
module scs_link_model (
    input  wire logic        clk_in,        // Clock
    input  wire logic        rst_n_in,      // Async reset, low
    input  wire logic        attach_req_in, // Session setup request
    input  wire logic        read_req_in,   // Read request pulse
    input  wire logic [15:0] bytes_in,      // Bytes asked for
    output logic             done_out,      // Setup done pulse
    output logic             valid_out,     // Word valid pulse
    output logic             last_out,      // Last word flag
    output logic      [15:0] data_out       // Response word
);
    logic [3:0]  wait_cnt; // Slow setup answer
    logic [15:0] left;     // Words still owed
    // Setup answered after a delay; words every other cycle, count first
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {wait_cnt, left, done_out, valid_out, last_out, data_out} <= '0;
        end else begin
            wait_cnt  <= attach_req_in ? wait_cnt + 4'h1 : 4'h0;
            done_out  <= attach_req_in && (wait_cnt == 4'h3);
            valid_out <= 1'b0;
            last_out  <= 1'b0;
            data_out  <= ~data_out; // Never a stale word between beats
            if (read_req_in) begin
                left <= bytes_in >> 1;
            end else if (left != 16'h0 && !valid_out) begin
                valid_out <= 1'b1;
                last_out  <= (left == 16'h1);
                data_out  <= 16'ha5a0 + left;
                left      <= left - 16'h1;
            end
        end
    end
endmodule : scs_link_model

// >>> test/tb_serial_session_cmd_handler.sv
`timescale 1ns/1ps
module tb_serial_session_cmd_handler;
    import scs_pkg::*;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 0;
    logic [31:0] wd = 0;
    wire logic [31:0] rd;
    wire logic ack, den, flt, areq, amul, rreq, twe, dn, rv, rl;
    wire logic [63:0] sid;
    wire logic [15:0] sty, sad, rb, rdat, tty, tad, tdat;
    int fail_count = 0, tests_run = 0, nd;
    logic ses_act = 0, idle_tmo = 0;  // Slave session level, link-idle pulse
    logic [15:0] sst = 0;             // Slave controller status word
    logic [31:0] q;                   // Bus read result
    always #2.5 clk = ~clk;
    scs_link_model peer (.clk_in(clk), .rst_n_in(rst_n), .attach_req_in(areq), .read_req_in(rreq),
        .bytes_in(rb), .done_out(dn), .valid_out(rv), .last_out(rl), .data_out(rdat));
    scs_cmd_handler #(.CYC_PER_MS(10), .DEF_TMO_MS(16'd2)) dut (.ref_clk_in(clk), .rst_n_in(rst_n),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
        .wb_dat_in(wd), .wb_dat_out(rd), .wb_ack_out(ack), .session_active_in(ses_act),
        .link_idle_tmo_in(idle_tmo), .detect_en_out(den), .fault_out(flt), .attach_req_out(areq),
        .attach_multi_out(amul), .attach_done_in(dn), .attach_err_in(1'b0), .read_req_out(rreq),
        .slave_id_out(sid), .slave_type_out(sty), .slave_addr_out(sad), .read_bytes_out(rb),
        .rsp_valid_in(rv), .rsp_data_in(rdat), .rsp_last_in(rl), .rsp_err_in(1'b0),
        .slave_status_in(sst), .tab_we_out(twe), .tab_type_out(tty), .tab_addr_out(tad),
        .tab_data_out(tdat));
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Classic single write, held until ack
    task wb(input logic [7:0] a, input logic [15:0] d);
        int n;
        {cyc, stb, we, adr, wd} <= {3'b111, a, 16'h0, d};
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
        if (n == 20) begin fail_count++; finish_test(); end
        {cyc, stb, we} <= 3'b000;
        @(posedge clk);
    endtask : wb
    // Classic single read, data taken at the ack edge
    task wbr(input logic [7:0] a, output logic [31:0] d);
        int n;
        {cyc, stb, we, adr} <= {3'b110, a};
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
        if (n == 20) begin fail_count++; finish_test(); end
        d = rd;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask : wbr
    // Start a command, collect table writes until the first write outside the analog input table lands
    task go(input logic [15:0] cmd, input logic [15:0] exp);
        int n;
        wb(8'h1c, cmd);
        wb(A_CTRL, 16'h1);
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            if (twe === 1'b1 && tty === MT_AI) begin
                chk(tdat, 16'ha5a2 - nd[15:0]);
                chk(tad, 16'h1 + nd[15:0]);
                nd++;
            end else if (twe === 1'b1) break;
        end
        if (n == 400) begin fail_count++; finish_test(); end
        chk(tdat, exp);
        repeat (2) @(posedge clk);
    endtask : go
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        chk({15'h0, den}, 16'h1);
        wb(8'h00, TASK_P1); // First request right after start-up
        wb(8'h04, 16'h1);
        wb(8'h08, MODE_ASYNC);
        wb(8'h0c, MT_R);
        wb(8'h10, 16'h0);
        go(CMD_BF_EN, ST_OK);
        wb(8'h08, 16'h1);
        go(CMD_BF_EN, ST_WAIT);
        wb(8'h08, MODE_ASYNC);
        wb(A_CTRL, 16'h2);
        chk({15'h0, den}, 16'h0);
        go(CMD_BF_EN, ST_OK);
        chk({15'h0, den}, 16'h1);
        wb(A_CFG, 16'h1);
        go(CMD_BF_EN, ST_NOSUP);
        wb(8'h00, TASK_PS);
        wb(8'h1c, CMD_BF_EN);
        wb(A_CTRL, 16'h1);
        repeat (6) @(posedge clk);
        chk({15'h0, flt}, 16'h1);
        wb(A_CFG, 16'h3);
        for (int i = 8; i < 20; i++) wb(8'(4 * i), (i == 13) ? MT_R : (i == 16) ? MT_AI : 16'h0);
        wb(8'h20, 16'h0); // Null id low word, never broadcast
        wb(8'h30, 16'h0); // Single session
        wb(8'h04, MIN_XLEN);
        wb(8'h3c, 16'h2);
        wb(8'h44, 16'h1);
        nd = 0;
        go(CMD_XREAD, ST_OK);
        chk(nd[15:0], 16'h2);
        wb(8'h04, 16'd10);
        go(CMD_XREAD, ST_PARM);
        wbr(A_RES, q);
        chk(q[15:0], ST_PARM);
        wb(8'h04, MIN_XLEN);
        wb(8'h48, MT_R);
        wb(8'h4c, 16'h20);
        sst <= 16'h1234;
        nd = 0;
        go(CMD_XREAD, 16'h1234);
        chk(nd[15:0], 16'h2);
        wb(8'h0c, 16'h0);
        wb(A_CTRL, 16'h1);
        repeat (6) @(posedge clk);
        chk({15'h0, flt}, 16'h1);
        wb(8'h0c, MT_R);
        wb(A_CTRL, 16'h2);
        ses_act <= 1'b1;
        go(CMD_BF_EN, ST_OK);
        wbr(A_STAT, q);
        chk(q[15:0], 16'h0032);
        idle_tmo <= 1'b1;
        @(posedge clk);
        idle_tmo <= 1'b0;
        @(posedge clk);
        chk({15'h0, den}, 16'h1);
        wb(A_CFG, 16'h2);
        go(CMD_BF_EN, ST_NOSUP);
        finish_test();
    end
endmodule : tb_serial_session_cmd_handler
